// *** hdl/cache_stage_params.svh ***
`ifndef CACHE_STAGE_PARAMS_SVH
`define CACHE_STAGE_PARAMS_SVH

// Address fields of a slave access
`define ADDR_SPACE_BIT 14
`define ADDR_REG_BIT 3
`define ADDR_WORD_BIT 2
`define ADDR_TGT_HI 22
`define ADDR_TGT_LO 19
`define ADDR_BANK_HI 18
`define ADDR_BANK_LO 15
`define ADDR_IDX_HI 13
`define ADDR_IDX_LO 2

// Target codes in the block select field
`define TGT_SINGLE 4'h0
`define TGT_TAG 4'h1
`define TGT_DIRTY 4'h2
`define TGT_DOUBLE 4'h4
`define TGT_STROBED 4'h8

// Protection configuration codes
`define PROT_NONE 2'h0
`define PROT_PARITY 2'h1
`define PROT_ECC 2'h2

// Valid bit layouts of the staging registers
`define MASK_ALL 64'hffffffffffffffff
`define MASK_NONE 64'h0000000000000000
`define MASK_SB_PAR 64'h000000000000000f
`define MASK_SB_ECC 64'h000000000000007f
`define MASK_IC_CHK 64'h00000000000000ff
`define MASK_DB_ECC 64'h0000000000007f7f
`define MASK_DB_PAR 64'h0000000000000f0f
`define MASK_TAG_ECC 64'h000000003fffffff
`define MASK_TAG_PAR 64'h0000000000ffffff
`define MASK_TAG_NONE 64'h00000000007fffff
`define MASK_DIRTY_ECC 64'h000000007f7f7f7f
`define MASK_DIRTY_NONE 64'h0000000007070707

// Byte enables and word lanes
`define BE_ALL 8'hff
`define BE_LOW 8'h0f
`define BE_HIGH 8'hf0
`define WORD_ZERO 32'h00000000

`endif

// *** hdl/cache_stage_pkg.sv ***
package cache_stage_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RAM,
        ST_RESP
    } stage_state_e;

    typedef logic [1:0] prot_t;
    typedef logic [3:0] target_t;

endpackage

// *** hdl/stage_reg.sv ***
`timescale 1ns/1ps
`include "cache_stage_params.svh"

module stage_reg #(
    parameter int BYTES = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Whole load or byte merge
    input wire logic load,
    input wire logic [BYTES*8-1:0] load_val,
    input wire logic [BYTES-1:0] be,
    input wire logic [BYTES*8-1:0] wval,
    // Contents
    output logic [BYTES*8-1:0] q
);

    wire logic [BYTES*8-1:0] next_q;

    genvar i;
    generate
        for (i = 0; i < BYTES; i = i + 1) begin : g_byte
            assign next_q[i*8 +: 8] = load ? load_val[i*8 +: 8] :
                                      be[i] ? wval[i*8 +: 8] : q[i*8 +: 8];
        end
    endgenerate

    // One process owns the whole register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= {BYTES{8'h00}};
        end else if (ce) begin
            q <= next_q;
        end
    end

endmodule

// *** hdl/stage_layout.sv ***
`timescale 1ns/1ps
`include "cache_stage_params.svh"

module stage_layout
    import cache_stage_pkg::*;
(
    // Access description
    input wire logic dcache,
    input wire target_t target,
    input wire prot_t dprot,
    input wire prot_t iprot,
    // Bits that really reach the RAM
    output logic [63:0] data_mask,
    output logic [63:0] check_mask
);

    wire logic is_tag;
    wire logic is_dirty;
    wire logic is_single;
    wire prot_t prot;
    assign prot = dcache ? dprot : iprot;
    assign is_tag = (target == `TGT_TAG);
    assign is_dirty = (target == `TGT_DIRTY);
    assign is_single = (target == `TGT_SINGLE);

    assign data_mask =
        is_tag ? ((prot == `PROT_ECC) ? `MASK_TAG_ECC :
                  (prot == `PROT_PARITY) ? `MASK_TAG_PAR : `MASK_TAG_NONE) :
        is_dirty ? ((prot == `PROT_ECC) ? `MASK_DIRTY_ECC
                                        : `MASK_DIRTY_NONE) :
        `MASK_ALL;

    assign check_mask =
        (is_tag || is_dirty || prot == `PROT_NONE) ? `MASK_NONE :
        !dcache ? `MASK_IC_CHK :
        is_single ? ((prot == `PROT_ECC) ? `MASK_SB_ECC : `MASK_SB_PAR) :
        ((prot == `PROT_ECC) ? `MASK_DB_ECC : `MASK_DB_PAR);

endmodule

// *** hdl/cache_ram_stage.sv ***
// Behaviour
// - Window write merges staging, then commits RAM
// - Window read loads staging, returns staged data
// - Staging space accesses never touch RAM
// - Staging persists; RAM reads overwrite both
// - Check register errors when nothing protected
// - Index bit zero picks single-bank word
// - Low word merges bus and staging bytes
// - Low read fills low, clears upper
// - High word merges by strobes
// - High read fills upper staging word
// - Single-bank parity sits in bits 3:0
// - Instruction check bits sit in 7:0
// - Double-bank all bytes, strobed by strobes
// - Double-bank check codes 14:8 and 6:0
// - Double-bank parity 11:8 and 3:0
// - Unprotected data check reads zero
// - Tag with code: tag, valid, code
// - Tag with parity: single bit 23
// - Unprotected tag: tag and valid only
// - Dirty with code: four 7-bit lanes
// - Dirty without code: lane bits 2:0
// - Bit 14 space, bit 3 register
// - Bits 22:19 select the RAM target
// - Undefined addresses answer slave error
`timescale 1ns/1ps
`include "cache_stage_params.svh"

module cache_ram_stage
    import cache_stage_pkg::*;
#(
    parameter prot_t DCACHE_PROT = `PROT_ECC,
    parameter prot_t ICACHE_PROT = `PROT_ECC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Slave request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_dcache,
    input wire logic [22:0] slave_access_address,
    input wire logic [63:0] req_wdata,
    input wire logic [7:0] req_wstrb,
    // Slave response
    output logic resp_valid,
    output logic resp_err,
    output logic [63:0] resp_rdata,
    // Cache RAM port
    output logic ram_req,
    output logic ram_write,
    output logic ram_dcache,
    output logic [3:0] ram_target,
    output logic [3:0] ram_bank,
    output logic [11:0] ram_index,
    output logic [63:0] ram_wdata,
    output logic [63:0] ram_wcheck,
    output logic [7:0] ram_byte_en,
    input wire logic ram_ack,
    input wire logic [63:0] ram_rdata,
    input wire logic [63:0] ram_rcheck
);

    stage_state_e state;
    stage_state_e next_state;

    logic a_write;
    logic a_dcache;
    logic [22:0] a_addr;
    logic [7:0] a_wstrb;

    wire logic [63:0] data_q;
    wire logic [63:0] check_q;
    wire logic [63:0] data_mask;
    wire logic [63:0] check_mask;

    // Request decode
    wire logic take;
    wire logic sp_stage;
    wire logic sp_check;
    wire target_t tgt;
    wire logic [3:0] bank;
    wire logic bank_onehot;
    wire logic tgt_ok;
    wire logic stage_ok;
    wire logic any_prot;
    wire logic dec_err;
    wire logic ram_go;

    assign req_ready = (state == ST_IDLE);
    assign take = req_valid && req_ready && ce;
    assign sp_stage = slave_access_address[`ADDR_SPACE_BIT];
    assign sp_check = slave_access_address[`ADDR_REG_BIT];
    assign tgt = slave_access_address[`ADDR_TGT_HI:`ADDR_TGT_LO];
    assign bank = slave_access_address[`ADDR_BANK_HI:`ADDR_BANK_LO];
    assign bank_onehot = (bank != 4'h0) && ((bank & (bank - 4'h1)) == 4'h0);
    assign any_prot = (DCACHE_PROT != `PROT_NONE) ||
                      (ICACHE_PROT != `PROT_NONE);

    assign tgt_ok =
        (tgt == `TGT_SINGLE) ? bank_onehot :
        (tgt == `TGT_TAG) ? (req_write ? (bank != 4'h0) : bank_onehot) :
        (tgt == `TGT_DIRTY) ? (req_dcache && bank != 4'h0) :
        (tgt == `TGT_DOUBLE || tgt == `TGT_STROBED) ?
            (req_dcache && bank_onehot) : 1'b0;

    assign stage_ok = (slave_access_address[22:15] == 8'h00) &&
                      (slave_access_address[13:4] == 10'h000) &&
                      (!sp_check || any_prot);

    assign dec_err = sp_stage ? !stage_ok : !tgt_ok;
    assign ram_go = take && !sp_stage && !dec_err;

    // Latched access for the RAM phase
    wire logic a_single;
    wire logic a_idx0;
    wire target_t a_tgt;
    assign a_tgt = a_addr[`ADDR_TGT_HI:`ADDR_TGT_LO];
    assign a_single = (a_tgt == `TGT_SINGLE) && a_dcache;
    assign a_idx0 = a_addr[`ADDR_WORD_BIT];

    // Staging write merge at request time
    wire logic req_single;
    wire logic req_idx0;
    wire logic [7:0] win_be;
    wire logic wr_data_stage;
    wire logic wr_check_stage;
    assign req_single = (tgt == `TGT_SINGLE) && req_dcache;
    assign req_idx0 = slave_access_address[`ADDR_WORD_BIT];
    assign win_be = !req_single ? req_wstrb :
                    req_idx0 ? (req_wstrb & `BE_HIGH) :
                               (req_wstrb & `BE_LOW);
    assign wr_data_stage = take && req_write && !dec_err &&
                           (!sp_stage || !sp_check);
    assign wr_check_stage = take && req_write && !dec_err &&
                            sp_stage && sp_check;

    // Staging load after a RAM read
    wire logic rd_done;
    wire logic data_load;
    wire logic [63:0] rd_masked;
    wire logic [63:0] rd_data_val;
    wire logic [63:0] rd_check_val;
    wire logic [63:0] next_data_rd;
    assign rd_done = (state == ST_RAM) && !a_write && ram_ack && ce;
    assign rd_masked = ram_rdata & data_mask;
    assign rd_data_val = a_single ? {`WORD_ZERO, rd_masked[31:0]}
                                  : rd_masked;
    assign rd_check_val = ram_rcheck & check_mask;
    assign data_load = rd_done && !(a_single && a_idx0);
    assign next_data_rd = (a_single && a_idx0) ?
                          {rd_masked[31:0], data_q[31:0]} : rd_data_val;

    wire logic [7:0] data_be;
    wire logic [63:0] data_wval;
    assign data_be = (rd_done && a_single && a_idx0) ? `BE_HIGH :
                     !wr_data_stage ? 8'h00 :
                     sp_stage ? req_wstrb : win_be;
    assign data_wval = rd_done ? {rd_masked[31:0], `WORD_ZERO} : req_wdata;

    stage_reg #(
        .BYTES(8)
    ) u_data_stage (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .load(data_load),
        .load_val(rd_data_val),
        .be(data_be),
        .wval(data_wval),
        .q(data_q)
    );

    stage_reg #(
        .BYTES(8)
    ) u_check_stage (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .load(rd_done),
        .load_val(rd_check_val),
        .be(wr_check_stage ? req_wstrb : 8'h00),
        .wval(req_wdata),
        .q(check_q)
    );

    stage_layout u_layout (
        .dcache(a_dcache),
        .target(a_tgt),
        .dprot(DCACHE_PROT),
        .iprot(ICACHE_PROT),
        .data_mask(data_mask),
        .check_mask(check_mask)
    );

    // RAM port
    wire logic [63:0] wr_masked;
    assign wr_masked = data_q & data_mask;
    assign ram_req = (state == ST_RAM);
    assign ram_write = a_write;
    assign ram_dcache = a_dcache;
    assign ram_target = a_tgt;
    assign ram_bank = a_addr[`ADDR_BANK_HI:`ADDR_BANK_LO];
    assign ram_index = a_addr[`ADDR_IDX_HI:`ADDR_IDX_LO];
    assign ram_wdata = !a_single ? wr_masked :
                       a_idx0 ? {`WORD_ZERO, wr_masked[63:32]} :
                                {`WORD_ZERO, wr_masked[31:0]};
    assign ram_wcheck = check_q & check_mask;
    assign ram_byte_en = a_single ? `BE_LOW :
                         (a_tgt == `TGT_STROBED) ? a_wstrb : `BE_ALL;

    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = ram_go ? ST_RAM : ST_RESP;
                end
            end
            ST_RAM: begin
                if (ram_ack) begin
                    next_state = ST_RESP;
                end
            end
            ST_RESP: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_write <= 1'b0;
            a_dcache <= 1'b0;
            a_addr <= 23'h000000;
            a_wstrb <= 8'h00;
        end else if (take) begin
            a_write <= req_write;
            a_dcache <= req_dcache;
            a_addr <= slave_access_address;
            a_wstrb <= req_wstrb;
        end
    end

    // Response
    wire logic [63:0] stage_rd;
    assign stage_rd = sp_check ? check_q : data_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_err <= 1'b0;
            resp_rdata <= 64'h0000000000000000;
        end else if (ce) begin
            if (take) begin
                resp_err <= dec_err;
                resp_rdata <= (sp_stage && !dec_err && !req_write) ?
                              stage_rd : 64'h0000000000000000;
            end else if (rd_done) begin
                resp_rdata <= next_data_rd;
            end
        end
    end

    assign resp_valid = (state == ST_RESP);

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    stage_no_ram_a: assert property (
        take && sp_stage |=> !ram_req)
        else $error("staging access started a RAM access");

    ram_window_go_a: assert property (
        take && !sp_stage && !dec_err && ce |=> ram_req)
        else $error("window access did not reach the RAM");

    check_err_a: assert property (
        take && sp_stage && sp_check && !any_prot |=> resp_valid && resp_err)
        else $error("check register access not refused");

    unmapped_err_a: assert property (
        take && !sp_stage && !tgt_ok |=> resp_valid && resp_err && !ram_req)
        else $error("undefined target not refused");

    low_read_clear_a: assert property (
        rd_done && a_single && !a_idx0 |=> data_q[63:32] == 32'h00000000)
        else $error("upper staging word not cleared");

    high_read_keep_a: assert property (
        rd_done && a_single && a_idx0 |=>
        data_q[31:0] == $past(data_q[31:0]) &&
        data_q[63:32] == $past(rd_masked[31:0]))
        else $error("upper word read misplaced");

    reserved_clean_a: assert property (
        ram_req && ram_write |->
        ((ram_wcheck & ~check_mask) == 64'h0000000000000000))
        else $error("reserved check bits reached the RAM");

    strobed_be_a: assert property (
        ram_req && a_tgt == `TGT_STROBED |-> ram_byte_en == a_wstrb)
        else $error("strobed access byte enables wrong");

    persist_a: assert property (
        state == ST_IDLE && !take |=> data_q == $past(data_q))
        else $error("staging data changed without access");

    resp_bound_a: assert property (
        ram_req && ram_ack && ce |=> resp_valid)
        else $error("no answer after RAM acknowledge");

    window_read_c: cover property (rd_done ##1 resp_valid);
    window_write_c: cover property (ram_req && ram_write && ram_ack);
    stage_write_c: cover property (wr_check_stage);
    error_c: cover property (resp_valid && resp_err);

endmodule

// *** dv/cache_ram_model.sv ***
`timescale 1ns/1ps

module cache_ram_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Cache RAM port
    input wire logic ram_req,
    input wire logic ram_write,
    input wire logic [20:0] ram_key,
    input wire logic [63:0] ram_wdata,
    input wire logic [63:0] ram_wcheck,
    input wire logic [7:0] ram_byte_en,
    input wire logic [1:0] delay,
    output logic ram_ack,
    output logic [63:0] ram_rdata,
    output logic [63:0] ram_rcheck
);
    logic [63:0] mem_d [int];
    logic [63:0] mem_c [int];
    logic [63:0] old;
    logic go;
    int waited;
    int n_req;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ram_ack <= 1'b0;
            waited <= 0;
            n_req <= 0;
            ram_rdata <= 64'h0;
            ram_rcheck <= 64'h0;
        end else begin
            go = ram_req && !ram_ack && waited >= int'(delay);
            ram_ack <= go;
            waited <= (ram_req && !ram_ack && !go) ? waited + 1 : 0;
            old = mem_d.exists(ram_key) ? mem_d[ram_key] : {43'h0, ram_key};
            if (go) begin
                n_req <= n_req + 1;
            end
            if (go && ram_write) begin
                for (int i = 0; i < 8; i++) begin
                    if (ram_byte_en[i]) old[i*8+:8] = ram_wdata[i*8+:8];
                end
                mem_d[ram_key] = old;
                mem_c[ram_key] = ram_wcheck;
            end
            // Read lines churn outside an answer so nothing stale passes
            if (go && !ram_write) begin
                ram_rdata <= old;
                ram_rcheck <= mem_c.exists(ram_key) ? mem_c[ram_key] : 64'h0;
            end else begin
                ram_rdata <= ~ram_rdata;
                ram_rcheck <= ~ram_rcheck;
            end
        end
    end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
`include "cache_stage_params.svh"

module tb;
    import cache_stage_pkg::*;
    logic clk, rst_n, req_valid, req_write, req_dcache, ram_ack, err, e2;
    logic req_ready, resp_valid, resp_err, ram_req, ram_write, ram_dcache;
    logic resp_err2, ram_req2, ce;
    logic [22:0] slave_access_address, a;
    logic [63:0] req_wdata, ram_rdata, ram_rcheck, resp_rdata, ram_wdata;
    logic [63:0] ram_wcheck, ram_wdata2, ram_wcheck2, lw, lc, w2, c2;
    logic [63:0] sd, sc, rd, rnd, w;
    logic [7:0] req_wstrb, ram_byte_en, lb, st;
    logic [3:0] ram_target, ram_bank, t;
    logic [11:0] ram_index, x;
    logic [1:0] ram_delay;
    int n_fail, n_tests, cyc, n0;

    cache_ram_stage dut (.clk, .rst_n, .ce, .req_valid, .req_ready,
        .req_write, .req_dcache, .slave_access_address, .req_wdata,
        .req_wstrb, .resp_valid, .resp_err, .resp_rdata, .ram_req,
        .ram_write, .ram_dcache, .ram_target, .ram_bank, .ram_index,
        .ram_wdata, .ram_wcheck, .ram_byte_en, .ram_ack, .ram_rdata,
        .ram_rcheck);

    // Same traffic into a build without any protection
    cache_ram_stage #(.DCACHE_PROT(`PROT_NONE), .ICACHE_PROT(`PROT_NONE))
        dut_none (.clk, .rst_n, .ce, .req_valid, .req_ready(),
        .req_write, .req_dcache, .slave_access_address, .req_wdata,
        .req_wstrb, .resp_valid(), .resp_err(resp_err2), .resp_rdata(),
        .ram_req(ram_req2), .ram_write(), .ram_dcache(), .ram_target(),
        .ram_bank(), .ram_index(), .ram_wdata(ram_wdata2),
        .ram_wcheck(ram_wcheck2), .ram_byte_en(), .ram_ack, .ram_rdata,
        .ram_rcheck);

    cache_ram_model ram (.clk, .rst_n, .ram_req, .ram_write,
        .ram_key({ram_dcache, ram_target, ram_bank, ram_index}), .ram_wdata,
        .ram_wcheck, .ram_byte_en, .delay(ram_delay), .ram_ack, .ram_rdata,
        .ram_rcheck);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (ram_req && ram_ack) begin
            lw <= ram_wdata;
            lc <= ram_wcheck;
            lb <= ram_byte_en;
        end
        if (ram_req2 && ram_ack) begin
            w2 <= ram_wdata2;
            c2 <= ram_wcheck2;
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    function automatic logic [63:0] mrg(input logic [63:0] o, n,
                                        input logic [7:0] s);
        for (int i = 0; i < 8; i++) begin
            if (s[i]) o[i*8+:8] = n[i*8+:8];
        end
        return o;
    endfunction

    function automatic logic [22:0] win(input logic [3:0] tg, b,
                                        input logic [11:0] ix);
        return {tg, b, 1'b0, ix, 2'b00};
    endfunction

    function automatic logic [22:0] stg(input logic r);
        return {8'h0, 1'b1, 10'h0, r, 1'b0, 2'b00};
    endfunction

    task automatic chk(input string what, input logic [63:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    // One request, called at a falling edge, returns at a falling edge
    task automatic xfer(input logic wr, dc, input logic [22:0] ad,
                        input logic [63:0] wd, input logic [7:0] ws);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        ram_delay = 2'($urandom_range(0, 3));
        req_write = wr;
        req_dcache = dc;
        slave_access_address = ad;
        req_wdata = wd;
        req_wstrb = ws;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        while (resp_valid !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("resp_in_time", 64'h0, {63'h0, n >= 40});
        err = resp_err;
        e2 = resp_err2;
        rd = resp_rdata;
        @(negedge clk);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic tally_and_finish;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_dcache = 1'b1;
        slave_access_address = 23'h0;
        req_wdata = 64'h0;
        req_wstrb = 8'h0;
        ram_delay = 2'h0;
        ce = 1'b1;
        n_fail = 0;
        n_tests = 0;
        cyc = 0;
        sd = 64'h0;
        sc = 64'h0;
        repeat (20) @(negedge clk);
        chk("rst_ready", 64'h1, {63'h0, req_ready});
        chk("rst_rdata", 64'h0, resp_rdata);
        rst_n = 1'b1;
        @(negedge clk);
        void'($urandom(40468));
        for (int i = 0; i < 12; i++) begin
            rnd = {$urandom, $urandom};
            st = 8'($urandom);
            n0 = ram.n_req;
            xfer(1'b1, 1'b1, stg(i[0]), rnd, st);
            if (i[0]) sc = mrg(sc, rnd, st);
            else sd = mrg(sd, rnd, st);
            xfer(1'b0, 1'b1, stg(i[0]), 64'h0, 8'h0);
            chk("stage_rd", i[0] ? sc : sd, rd);
            chk("stage_no_ram", 64'(n0), 64'(ram.n_req));
            if (i[0]) chk("check_err_none", 64'h1, {63'h0, e2});
        end
        end_test("staging");
        for (int i = 0; i < 4; i++) begin
            x = 12'($urandom);
            x[0] = i[0];
            rnd = {$urandom, $urandom};
            st = (i < 2) ? 8'h00 : 8'($urandom);
            w = mrg(sd, rnd, st & (x[0] ? `BE_HIGH : `BE_LOW));
            xfer(1'b1, 1'b1, win(`TGT_SINGLE, 4'h1, x), rnd, st);
            if (x[0]) chk("sb_hi_wdata", {32'h0, w[63:32]}, lw & 64'hffffffff);
            else chk("sb_lo_wdata", {32'h0, w[31:0]}, lw & 64'hffffffff);
            chk("sb_wcheck", sc & `MASK_SB_ECC, lc);
            chk("sb_byte_en", 64'(`BE_LOW), 64'(lb));
            sd = w;
            sc = sc & `MASK_SB_ECC;
            xfer(1'b0, 1'b1, win(`TGT_SINGLE, 4'h1, x), 64'h0, 8'h0);
            if (x[0]) chk("sb_rd_hi", {32'h0, w[63:32]}, rd >> 32);
            else chk("sb_rd_lo", {32'h0, w[31:0]}, rd);
            if (!x[0]) sd = {32'h0, w[31:0]};
            xfer(1'b0, 1'b1, stg(1'b0), 64'h0, 8'h0);
            chk("sb_stage", sd, rd);
        end
        end_test("single_bank");
        for (int i = 0; i < 4; i++) begin
            sc = {$urandom, $urandom};
            xfer(1'b1, 1'b1, stg(1'b1), sc, `BE_ALL);
            t = i[0] ? `TGT_STROBED : `TGT_DOUBLE;
            x = 12'($urandom);
            rnd = {$urandom, $urandom};
            st = (i == 3) ? 8'h00 : 8'($urandom);
            w = mrg(sd, rnd, st);
            xfer(1'b1, 1'b1, win(t, 4'h2, x), rnd, st);
            chk("db_byte_en", 64'(i[0] ? st : `BE_ALL), 64'(lb));
            chk("db_wdata", w, lw);
            chk("db_wcheck", sc & `MASK_DB_ECC, lc);
            chk("db_wcheck_none", 64'h0, c2);
            sd = w;
            if (!i[0]) begin
                xfer(1'b0, 1'b1, win(t, 4'h2, x), 64'h0, 8'h0);
                chk("db_rd", w, rd);
                xfer(1'b0, 1'b1, stg(1'b1), 64'h0, 8'h0);
                chk("db_rcheck", sc & `MASK_DB_ECC, rd);
            end
        end
        end_test("double_bank");
        sc = {$urandom, $urandom};
        xfer(1'b1, 1'b1, stg(1'b1), sc, `BE_ALL);
        x = 12'($urandom) & 12'h3ff;
        rnd = {$urandom, $urandom};
        xfer(1'b1, 1'b1, win(`TGT_TAG, 4'h1, x), rnd, `BE_ALL);
        chk("tag_wdata", rnd & `MASK_TAG_ECC, lw);
        chk("tag_wdata_none", rnd & `MASK_TAG_NONE, w2);
        xfer(1'b0, 1'b1, win(`TGT_TAG, 4'h1, x), 64'h0, 8'h0);
        chk("tag_rd", rnd & `MASK_TAG_ECC, rd);
        xfer(1'b0, 1'b1, stg(1'b1), 64'h0, 8'h0);
        chk("tag_rcheck", 64'h0, rd);
        xfer(1'b1, 1'b1, win(`TGT_DIRTY, 4'hf, x), rnd, `BE_ALL);
        chk("dirty_wdata", rnd & `MASK_DIRTY_ECC, lw);
        chk("dirty_wdata_none", rnd & `MASK_DIRTY_NONE, w2);
        xfer(1'b1, 1'b1, stg(1'b1), sc, `BE_ALL);
        xfer(1'b1, 1'b0, win(`TGT_SINGLE, 4'h1, x), rnd, `BE_ALL);
        chk("ic_wcheck", sc & `MASK_IC_CHK, lc);
        end_test("layouts");
        sd = rnd;
        for (int i = 0; i < 4; i++) begin
            n0 = ram.n_req;
            a = (i == 0) ? win(4'h3, 4'h1, x)
              : (i == 1) ? win(`TGT_SINGLE, 4'h0, x)
              : (i == 2) ? (stg(1'b0) | 23'h100000)
              : win(`TGT_DIRTY, 4'h1, x);
            xfer(1'b1, i != 3, a, ~sd, `BE_ALL);
            chk("bad_addr_err", 64'h1, {63'h0, err});
            chk("bad_addr_no_ram", 64'(n0), 64'(ram.n_req));
        end
        xfer(1'b0, 1'b1, stg(1'b0), 64'h0, 8'h0);
        chk("bad_addr_stage", sd, rd);
        // A request while the block is frozen must not be taken
        ce = 1'b0;
        slave_access_address = stg(1'b0);
        req_write = 1'b1;
        req_wdata = ~sd;
        req_wstrb = `BE_ALL;
        req_valid = 1'b1;
        repeat (3) @(negedge clk);
        chk("ce_no_resp", 64'h0, {63'h0, resp_valid});
        req_valid = 1'b0;
        ce = 1'b1;
        xfer(1'b0, 1'b1, stg(1'b0), 64'h0, 8'h0);
        chk("ce_frozen", sd, rd);
        end_test("refusals");
        tally_and_finish();
    end
endmodule
